/* File: cdb_decoder.v */
// Read and pre-fetch command descriptor decoder with an Avalon-MM register port
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "cdb_decoder_defines.vh"

// What this block does
// - Pre-fetch 34h/90h loads cache, no data out
// - Pre-fetch address and length by form
// - Zero pre-fetch length fills segment or media end
// - Pre-fetch status waits for cache load done
// - Early-status bit set gives illegal request
// - Read6 address from byte1 low, bytes 2-3
// - Read6 zero length means 256 blocks
// - Read6 never sends or checks protection
// - Read10 address bytes 2-5, count 7-8
// - Read10 zero length seeks, then read-ahead
// - Zero-length read gives good status at once
// - Nonvolatile bypass bit accepted and ignored
// - Low-retention bit forces lowest cache priority
// - Bypass bit forces media read
// - Unformatted medium needs protection code zero
// - Code 000b sends and checks nothing
// - Codes 001b/010b send, check reference; guard 001b
// - Code 011b sends, checks nothing
// - Code 100b sends, checks guard only
// - Codes 101b-111b rejected as reserved
// - Protection failure aborts with field code
module cdb_decoder
(
  // Clock and reset
  input wire i_mclk,
  input wire i_reset_n,
  // Avalon-MM register slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Media, cache and protection side
  output reg o_media_start,
  output reg [63:0] o_media_lba,
  output reg [31:0] o_media_len,
  output reg o_media_to_host,
  output reg o_media_fill_segment,
  output reg o_media_bypass_cache,
  output reg [1:0] o_media_retention_prio,
  output reg o_pi_send,
  output reg o_pi_chk_guard,
  output reg o_pi_chk_app,
  output reg o_pi_chk_ref,
  output reg o_read_ahead_start,
  input wire i_media_done,
  input wire i_pi_fail_guard,
  input wire i_pi_fail_app,
  input wire i_pi_fail_ref,
  // Completion status toward the initiator
  output reg o_status_valid,
  output reg [7:0] o_scsi_status,
  output reg [3:0] o_sense_key,
  output reg [7:0] o_asc,
  output reg [7:0] o_ascq
);

  // ==========================================================
  // Declarations
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_DECODE = 2'h1;
  localparam [1:0] S_MEDIA = 2'h2;
  localparam [1:0] S_SEEK = 2'h3;

  reg [1:0] state;
  reg [7:0] cdb [0:15];
  reg [31:0] ctrl;
  reg done;
  reg seek_ra;
  wire acc_write;
  wire start_req;

  assign acc_write = i_avs_write && !o_avs_waitrequest;
  assign start_req = acc_write && (i_avs_address == `REG_CTRL) && i_avs_byteenable[0] &&
    i_avs_writedata[`CTRL_START_BIT] && (state == S_IDLE);

  // ==========================================================
  // Descriptor storage, byte n sits in word n/4, lane n%4
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_cdb
      always @(posedge i_mclk or negedge i_reset_n)
      begin
        if (!i_reset_n)
          cdb[gi] <= 8'h00;
        else if (acc_write && (i_avs_address == gi / 4) && i_avs_byteenable[gi % 4])
          cdb[gi] <= i_avs_writedata[(gi % 4) * 8 +: 8];
      end
    end
  endgenerate

  // ==========================================================
  // Field extraction
  wire [7:0] opcode = cdb[0];
  wire [2:0] rp = cdb[1][`RDPROT_MSB:`RDPROT_LSB];
  wire pi_fmt = ctrl[`CTRL_PI_FMT_BIT];
  wire [1:0] cfg_prio = ctrl[`CTRL_PRIO_LSB +: 2];
  wire [63:0] lba_10 = {32'h00000000, cdb[2], cdb[3], cdb[4], cdb[5]};
  wire [63:0] lba_16 = {cdb[2], cdb[3], cdb[4], cdb[5], cdb[6], cdb[7], cdb[8], cdb[9]};
  wire [63:0] lba_6 = {43'h0, cdb[1][4:0], cdb[2], cdb[3]};
  wire [31:0] len_10 = {16'h0000, cdb[7], cdb[8]};
  wire [31:0] len_16 = {cdb[10], cdb[11], cdb[12], cdb[13]};

  // ==========================================================
  // Combinational decode of the stored descriptor
  reg d_bad_op;
  reg d_bad_field;
  reg d_zero_good;
  reg [63:0] d_lba;
  reg [31:0] d_len;
  reg d_to_host;
  reg d_fill;
  reg d_bypass;
  reg [1:0] d_prio;
  reg d_pi_send;
  reg d_chk_guard;
  reg d_chk_ref;

  always @*
  begin
    d_bad_op = 1'b0;
    d_bad_field = 1'b0;
    d_zero_good = 1'b0;
    d_lba = 64'h0000000000000000;
    d_len = 32'h00000000;
    d_to_host = 1'b0;
    d_fill = 1'b0;
    d_bypass = 1'b0;
    d_prio = cfg_prio;
    d_pi_send = 1'b0;
    d_chk_guard = 1'b0;
    d_chk_ref = 1'b0;
    case (opcode)
      `OP_PREFETCH10, `OP_PREFETCH16:
      begin
        // Data goes to the cache only
        d_to_host = 1'b0;
        if (opcode == `OP_PREFETCH10)
        begin
          d_lba = lba_10;
          d_len = len_10;
        end
        else
        begin
          d_lba = lba_16;
          d_len = len_16;
        end
        d_fill = (d_len == 32'h00000000);
        d_bad_field = cdb[1][`EARLY_STATUS_BIT];
      end
      `OP_READ6:
      begin
        d_to_host = 1'b1;
        d_lba = lba_6;
        // A protected medium still reads plain data here
        d_len = (cdb[4] == 8'h00) ? `READ6_ZERO_LEN : {24'h000000, cdb[4]};
      end
      `OP_READ10:
      begin
        d_to_host = 1'b1;
        d_lba = lba_10;
        d_len = len_10;
        d_zero_good = (len_10 == 32'h00000000);
        d_bypass = cdb[1][`BYPASS_BIT];
        d_prio = cdb[1][`LOW_RET_BIT] ? `PRIO_LOWEST : cfg_prio;
        // The nonvolatile bypass bit is never looked at: no such cache exists
        if (!pi_fmt && (rp != `RP_NONE))
          d_bad_field = 1'b1;
        else
        begin
          case (rp)
            `RP_NONE: d_pi_send = 1'b0;
            `RP_ALL:
            begin
              d_pi_send = 1'b1;
              d_chk_guard = 1'b1;
              d_chk_ref = 1'b1;
            end
            `RP_NO_GUARD:
            begin
              d_pi_send = 1'b1;
              d_chk_ref = 1'b1;
            end
            `RP_NO_CHECK: d_pi_send = 1'b1;
            `RP_GUARD_ONLY:
            begin
              d_pi_send = 1'b1;
              d_chk_guard = 1'b1;
            end
            default:
            begin
              d_bad_field = 1'b1;
            end
          endcase
        end
      end
      default:
      begin
        d_bad_op = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Command sequencer
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= S_IDLE;
      done <= 1'b0;
      seek_ra <= 1'b0;
      o_media_start <= 1'b0;
      o_media_lba <= 64'h0000000000000000;
      o_media_len <= 32'h00000000;
      o_media_to_host <= 1'b0;
      o_media_fill_segment <= 1'b0;
      o_media_bypass_cache <= 1'b0;
      o_media_retention_prio <= 2'h0;
      o_pi_send <= 1'b0;
      o_pi_chk_guard <= 1'b0;
      o_pi_chk_app <= 1'b0;
      o_pi_chk_ref <= 1'b0;
      o_read_ahead_start <= 1'b0;
      o_status_valid <= 1'b0;
      o_scsi_status <= `ST_GOOD;
      o_sense_key <= `SK_NONE;
      o_asc <= `ASC_NONE;
      o_ascq <= `ASCQ_NONE;
    end
    else
    begin
      o_media_start <= 1'b0;
      o_read_ahead_start <= 1'b0;
      o_status_valid <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start_req)
          begin
            done <= 1'b0;
            state <= S_DECODE;
          end
        end
        S_DECODE:
        begin
          o_media_lba <= d_lba;
          o_media_len <= d_len;
          o_media_to_host <= d_to_host;
          o_media_fill_segment <= d_fill;
          o_media_bypass_cache <= d_bypass;
          o_media_retention_prio <= d_prio;
          o_pi_send <= d_pi_send;
          o_pi_chk_guard <= d_chk_guard;
          // Application tag checks belong to the long read only
          o_pi_chk_app <= 1'b0;
          o_pi_chk_ref <= d_chk_ref;
          o_ascq <= `ASCQ_NONE;
          if (d_bad_op)
          begin
            o_status_valid <= 1'b1;
            o_scsi_status <= `ST_CHECK;
            o_sense_key <= `SK_ILLEGAL;
            o_asc <= `ASC_INV_OPCODE;
            done <= 1'b1;
            state <= S_IDLE;
          end
          else if (d_bad_field)
          begin
            o_status_valid <= 1'b1;
            o_scsi_status <= `ST_CHECK;
            o_sense_key <= `SK_ILLEGAL;
            o_asc <= `ASC_INV_FIELD;
            done <= 1'b1;
            state <= S_IDLE;
          end
          else if (d_zero_good)
          begin
            // Good status goes out now; the seek runs on behind it
            o_status_valid <= 1'b1;
            o_scsi_status <= `ST_GOOD;
            o_sense_key <= `SK_NONE;
            o_asc <= `ASC_NONE;
            done <= 1'b1;
            o_media_start <= 1'b1;
            seek_ra <= ctrl[`CTRL_RA_EN_BIT];
            state <= S_SEEK;
          end
          else
          begin
            o_media_start <= 1'b1;
            state <= S_MEDIA;
          end
        end
        S_MEDIA:
        begin
          // Status is held back until the media side reports the load finished
          if (i_media_done)
          begin
            o_status_valid <= 1'b1;
            done <= 1'b1;
            state <= S_IDLE;
            if (o_pi_chk_guard && i_pi_fail_guard)
            begin
              o_scsi_status <= `ST_CHECK;
              o_sense_key <= `SK_ABORTED;
              o_asc <= `ASC_PI_FAIL;
              o_ascq <= `ASCQ_GUARD;
            end
            else if (o_pi_chk_app && i_pi_fail_app)
            begin
              o_scsi_status <= `ST_CHECK;
              o_sense_key <= `SK_ABORTED;
              o_asc <= `ASC_PI_FAIL;
              o_ascq <= `ASCQ_APP;
            end
            else if (o_pi_chk_ref && i_pi_fail_ref)
            begin
              o_scsi_status <= `ST_CHECK;
              o_sense_key <= `SK_ABORTED;
              o_asc <= `ASC_PI_FAIL;
              o_ascq <= `ASCQ_REF;
            end
            else
            begin
              o_scsi_status <= `ST_GOOD;
              o_sense_key <= `SK_NONE;
              o_asc <= `ASC_NONE;
              o_ascq <= `ASCQ_NONE;
            end
          end
        end
        S_SEEK:
        begin
          if (i_media_done)
          begin
            o_read_ahead_start <= seek_ra;
            state <= S_IDLE;
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Control register; the start bit is a strobe and never stored
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ctrl <= `CTRL_RESET;
    else if (acc_write && (i_avs_address == `REG_CTRL) && i_avs_byteenable[0])
      ctrl <= {24'h000000, i_avs_writedata[7:1], 1'b0};
  end

  // ==========================================================
  // Bus handshake: one wait cycle, read data loaded in that cycle
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end
    else if (!o_avs_waitrequest)
      o_avs_waitrequest <= 1'b1;
    else if (i_avs_read || i_avs_write)
    begin
      o_avs_waitrequest <= 1'b0;
      case (i_avs_address)
        `REG_CDB0: o_avs_readdata <= {cdb[3], cdb[2], cdb[1], cdb[0]};
        `REG_CDB1: o_avs_readdata <= {cdb[7], cdb[6], cdb[5], cdb[4]};
        `REG_CDB2: o_avs_readdata <= {cdb[11], cdb[10], cdb[9], cdb[8]};
        `REG_CDB3: o_avs_readdata <= {cdb[15], cdb[14], cdb[13], cdb[12]};
        `REG_CTRL: o_avs_readdata <= ctrl;
        `REG_SENSE: o_avs_readdata <= {o_ascq, o_asc, 4'h0, o_sense_key, o_scsi_status};
        `REG_STATE: o_avs_readdata <= {28'h0000000, state, done, (state != S_IDLE)};
        `REG_LBA_LO: o_avs_readdata <= o_media_lba[31:0];
        `REG_LBA_HI: o_avs_readdata <= o_media_lba[63:32];
        `REG_LEN: o_avs_readdata <= o_media_len;
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* File: cdb_decoder_defines.vh */
// Constants for the read and pre-fetch command descriptor decoder
`ifndef CDB_DECODER_DEFINES_VH
`define CDB_DECODER_DEFINES_VH

// Register word indexes (byte address is four times the index)
`define REG_CDB0 4'h0
`define REG_CDB1 4'h1
`define REG_CDB2 4'h2
`define REG_CDB3 4'h3
`define REG_CTRL 4'h4
`define REG_SENSE 4'h5
`define REG_STATE 4'h6
`define REG_LBA_LO 4'h7
`define REG_LBA_HI 4'h8
`define REG_LEN 4'h9

// Control register fields
`define CTRL_START_BIT 0
`define CTRL_PI_FMT_BIT 1
`define CTRL_RA_EN_BIT 2
`define CTRL_PRIO_LSB 4
`define CTRL_RESET 32'h00000000

// Operation codes
`define OP_PREFETCH10 8'h34
`define OP_PREFETCH16 8'h90
`define OP_READ6 8'h08
`define OP_READ10 8'h28

// Byte 1 field positions
`define RDPROT_MSB 7
`define RDPROT_LSB 5
`define LOW_RET_BIT 4
`define BYPASS_BIT 3
`define NV_BYPASS_BIT 1
`define EARLY_STATUS_BIT 1

// Protection check codes
`define RP_NONE 3'h0
`define RP_ALL 3'h1
`define RP_NO_GUARD 3'h2
`define RP_NO_CHECK 3'h3
`define RP_GUARD_ONLY 3'h4

// Status, sense keys and additional sense codes
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define SK_NONE 4'h0
`define SK_ILLEGAL 4'h5
`define SK_ABORTED 4'hB
`define ASC_NONE 8'h00
`define ASC_INV_OPCODE 8'h20
`define ASC_INV_FIELD 8'h24
`define ASC_PI_FAIL 8'h10
`define ASCQ_NONE 8'h00
`define ASCQ_GUARD 8'h01
`define ASCQ_APP 8'h02
`define ASCQ_REF 8'h03

// Lengths and retention priority
`define READ6_ZERO_LEN 32'h00000100
`define PRIO_LOWEST 2'h3

`endif

/* File: cdb_checker.sv */
// Port-level assertions for the descriptor decoder
`timescale 1ns/100ps
`include "cdb_decoder_defines.vh"
module cdb_checker
(
  // Clock, reset and bus
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  // Media side
  input wire o_media_start,
  input wire [31:0] o_media_len,
  input wire o_media_to_host,
  input wire o_media_fill_segment,
  input wire o_pi_send,
  input wire o_pi_chk_guard,
  input wire o_pi_chk_app,
  input wire o_pi_chk_ref,
  input wire i_media_done,
  input wire i_pi_fail_guard,
  input wire i_pi_fail_app,
  input wire i_pi_fail_ref,
  // Status
  input wire o_status_valid,
  input wire [7:0] o_scsi_status,
  input wire [3:0] o_sense_key,
  input wire [7:0] o_ascq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  reg pf_busy;
  // ==========
  // Pre-fetch in flight: no status may leave until the load ends
  always @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
      pf_busy <= 1'b0;
    else if (o_media_start && !o_media_to_host)
      pf_busy <= 1'b1;
    else if (i_media_done)
      pf_busy <= 1'b0;
  sequence s_ans;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  // ==========
  // Properties
  AST_BUS_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> s_ans)
    else $error("bus access not answered after one wait cycle");
  AST_START_PULSE: assert property (o_media_start |=> !o_media_start)
    else $error("media start longer than one cycle");
  AST_FILL_NO_HOST: assert property (o_media_fill_segment |-> !o_media_to_host)
    else $error("segment fill sends data to host");
  AST_PF_HOLD: assert property (pf_busy |-> !o_status_valid)
    else $error("pre-fetch status before load done");
  AST_NO_APP: assert property (!o_pi_chk_app)
    else $error("application tag check enabled");
  AST_PI_NONE: assert property (o_media_start && !o_pi_send |-> !o_pi_chk_guard && !o_pi_chk_ref)
    else $error("check enabled without protection send");
  AST_GUARD_FAIL: assert property (i_media_done && o_pi_chk_guard && i_pi_fail_guard
    && o_media_len != 32'h0 |=> o_status_valid && o_sense_key == `SK_ABORTED
    && o_ascq == `ASCQ_GUARD)
    else $error("guard failure not reported");
  AST_GOOD: assert property (i_media_done && !i_pi_fail_guard && !i_pi_fail_app
    && !i_pi_fail_ref && (o_media_len != 32'h0 || o_media_fill_segment)
    |=> o_status_valid && o_scsi_status == `ST_GOOD)
    else $error("no good status after clean completion");
  AST_STATUS_PULSE: assert property (o_status_valid |=> !o_status_valid)
    else $error("status valid longer than one cycle");
endmodule

bind cdb_decoder cdb_checker i_chk (.i_mclk, .i_reset_n, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .o_media_start, .o_media_len, .o_media_to_host, .o_media_fill_segment,
  .o_pi_send, .o_pi_chk_guard, .o_pi_chk_app, .o_pi_chk_ref, .i_media_done, .i_pi_fail_guard,
  .i_pi_fail_app, .i_pi_fail_ref, .o_status_valid, .o_scsi_status, .o_sense_key, .o_ascq);

/* File: media_model.sv */
// Behavioural media, cache and protection checker facing the decoder
`timescale 1ns/100ps
module media_model
(
  // Clock and reset
  input wire i_mclk,
  input wire i_reset_n,
  // Launch and bench controls
  input wire i_start,
  input wire [7:0] i_delay,
  input wire [2:0] i_fail,
  // Completion
  output reg o_done,
  output wire [2:0] o_fail
);
  reg [8:0] cnt;
  // Fail lines mean nothing outside done, so they show the inverse there
  assign o_fail = o_done ? i_fail : ~i_fail;
  always @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      cnt <= 9'h000;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= (cnt == 9'h001);
      if (i_start)
        cnt <= {1'b0, i_delay} + 9'h001;
      else if (cnt != 9'h000)
        cnt <= cnt - 9'h001;
    end
endmodule

/* File: testbench.sv */
// Register-level testbench for the descriptor decoder
`timescale 1ns/100ps
`include "cdb_decoder_defines.vh"
module testbench;
  reg i_mclk = 1'b0;
  reg i_reset_n = 1'b0;
  reg [3:0] i_avs_address = 4'h0;
  reg i_avs_read = 1'b0;
  reg i_avs_write = 1'b0;
  reg [31:0] i_avs_writedata = 32'h0;
  reg [7:0] dly = 8'h02;
  reg [2:0] fail = 3'h0;
  integer n_status = 0;
  integer n_ra = 0;
  integer base_status;
  integer base_ra;
  reg [2:0] c;
  reg [31:0] r;
  integer miscompares = 0;
  integer n_compared = 0;
  integer lat;
  integer j;
  wire [31:0] o_avs_readdata, o_media_len;
  wire [63:0] o_media_lba;
  wire [1:0] o_media_retention_prio;
  wire [7:0] o_scsi_status, o_asc, o_ascq;
  wire [3:0] o_sense_key;
  wire o_avs_waitrequest, o_media_start, o_media_to_host, o_media_fill_segment;
  wire o_media_bypass_cache, o_pi_send, o_pi_chk_guard, o_pi_chk_app, o_pi_chk_ref;
  wire o_read_ahead_start, o_status_valid, i_media_done, i_pi_fail_guard;
  wire i_pi_fail_app, i_pi_fail_ref;
  localparam [27:0] good = {`ST_GOOD, `SK_NONE, `ASC_NONE, `ASCQ_NONE};
  localparam [27:0] bad_field = {`ST_CHECK, `SK_ILLEGAL, `ASC_INV_FIELD, `ASCQ_NONE};
  localparam [27:0] pi_bad = {`ST_CHECK, `SK_ABORTED, `ASC_PI_FAIL, 8'h00};

  cdb_decoder i_dut (.i_mclk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable(4'hF), .o_avs_readdata, .o_avs_waitrequest,
    .o_media_start, .o_media_lba, .o_media_len, .o_media_to_host, .o_media_fill_segment,
    .o_media_bypass_cache, .o_media_retention_prio, .o_pi_send, .o_pi_chk_guard,
    .o_pi_chk_app, .o_pi_chk_ref, .o_read_ahead_start, .i_media_done, .i_pi_fail_guard,
    .i_pi_fail_app, .i_pi_fail_ref, .o_status_valid, .o_scsi_status, .o_sense_key, .o_asc,
    .o_ascq);
  media_model i_media (.i_mclk, .i_reset_n, .i_start(o_media_start), .i_delay(dly),
    .i_fail(fail), .o_done(i_media_done),
    .o_fail({i_pi_fail_guard, i_pi_fail_app, i_pi_fail_ref}));

  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    if (o_status_valid)
      n_status <= n_status + 1;
    if (o_read_ahead_start)
      n_ra <= n_ra + 1;
  end

  // ==========
  // Tasks
  task close_out;
  begin
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task chk(input [63:0] g, input [63:0] e);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  end
  endtask
  task stat(input [27:0] e);
    chk({o_scsi_status, o_sense_key, o_asc, o_ascq}, e);
  endtask
  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= 1'b1;
    @(posedge i_mclk);
    while (o_avs_waitrequest)
      @(posedge i_mclk);
    i_avs_write <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, output [31:0] d);
  begin
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_read <= 1'b1;
    @(posedge i_mclk);
    while (o_avs_waitrequest)
      @(posedge i_mclk);
    d = o_avs_readdata;
    i_avs_read <= 1'b0;
  end
  endtask
  // Bytes given most significant first, byte 0 lands in lane 0 of word 0
  function [127:0] be(input [127:0] s);
    integer n;
  begin
    for (n = 0; n < 16; n = n + 1)
      be[8*n +: 8] = s[127-8*n -: 8];
  end
  endfunction
  // Waits for idle so a zero-length seek never overlaps the next command
  task cmd(input [127:0] d, input [31:0] ctl);
    integer k;
  begin
    for (k = 0; k < 4; k = k + 1)
      wr(k[3:0], d[32*k +: 32]);
    base_status = n_status;
    base_ra = n_ra;
    wr(`REG_CTRL, ctl | 32'h1);
    for (lat = 0; lat < 300 && n_status == base_status; lat = lat + 1)
      @(posedge i_mclk);
    chk(n_status - base_status, 1);
    r = 32'h1;
    while (r[0])
      rd(`REG_STATE, r);
  end
  endtask

  // ==========
  // Tests
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(`REG_CTRL, r);
    chk(r, `CTRL_RESET);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF, r);
    chk(r, 0);
    cmd(be({80'h28_1A_11223344_00_0102_00, 48'h0}), 32'h10);
    stat(good);
    chk(o_media_lba, 64'h11223344);
    chk(o_media_len, 32'h102);
    chk({o_media_to_host, o_media_bypass_cache, o_media_retention_prio, o_pi_send},
      {2'b11, `PRIO_LOWEST, 1'b0});
    cmd(be({80'h28_00_00000005_00_0001_00, 48'h0}), 32'h10);
    chk({o_media_bypass_cache, o_media_retention_prio}, 3'h1);
    cmd(be({48'h08_1F_ABCD_00_00, 80'h0}), 32'h12);
    chk(o_media_lba, 64'h1FABCD);
    chk(o_media_len, 32'h100);
    chk({o_media_to_host, o_pi_send, o_pi_chk_guard, o_pi_chk_ref}, 4'h8);
    dly <= 8'h28;
    cmd(be({80'h34_00_0000A000_00_0000_00, 48'h0}), 32'h10);
    stat(good);
    chk(lat > 40, 1);
    chk({o_media_len, o_media_fill_segment, o_media_to_host}, {32'h0, 2'b10});
    chk(o_media_lba, 64'hA000);
    cmd(be(128'h90_00_0102030405060708_0A0B0C0D_00_00), 32'h10);
    chk(o_media_lba, 64'h0102030405060708);
    chk({o_media_len, o_media_fill_segment}, {32'h0A0B0C0D, 1'b0});
    dly <= 8'h02;
    cmd(be({80'h34_02_00000001_00_0001_00, 48'h0}), 32'h10);
    stat(bad_field);
    cmd(be({80'h28_20_00000001_00_0001_00, 48'h0}), 32'h10);
    stat(bad_field);
    for (j = 0; j < 8; j = j + 1)
    begin
      c = j[2:0];
      cmd(be({8'h28, c, 5'h0, 32'h10, 8'h0, 16'h1, 8'h0, 48'h0}), 32'h12);
      if (j < 5)
        chk({o_pi_send, o_pi_chk_guard, o_pi_chk_ref},
          {c != 3'h0, c == 3'h1 || c == 3'h4, c == 3'h1 || c == 3'h2});
      else
        stat(bad_field);
    end
    fail <= 3'b100;
    cmd(be({80'h28_20_00000001_00_0001_00, 48'h0}), 32'h12);
    stat(pi_bad | `ASCQ_GUARD);
    fail <= 3'b001;
    cmd(be({80'h28_80_00000001_00_0001_00, 48'h0}), 32'h12);
    stat(good);
    fail <= 3'b111;
    cmd(be({80'h28_40_00000001_00_0001_00, 48'h0}), 32'h12);
    stat(pi_bad | `ASCQ_REF);
    fail <= 3'b000;
    dly <= 8'h14;
    cmd(be({80'h28_00_00000077_00_0000_00, 48'h0}), 32'h14);
    stat(good);
    chk(lat < 10, 1);
    chk(o_media_len, 32'h0);
    chk(n_ra - base_ra, 1);
    cmd(be({80'h28_00_00000078_00_0000_00, 48'h0}), 32'h10);
    stat(good);
    chk(n_ra - base_ra, 0);
    cmd(be({8'h2A, 120'h0}), 32'h10);
    stat({`ST_CHECK, `SK_ILLEGAL, `ASC_INV_OPCODE, `ASCQ_NONE});
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    miscompares = miscompares + 1;
    close_out;
  end
endmodule
